// ===== logic/sipw_top.sv
// periodic timer, watchdog service, edge flags and chip-select pin assignment behind an AHB-Lite slave
//
// Notes on behaviour
// - prescale bit: divide by 1 or 512
// - slow reference: modulus times prescale times four
// - fast reference: further multiplied by 128
// - external clock: four system clocks per count
// - watchdog restarts only after 55 then AA
// - other accesses may sit between both writes
// - selected edge sets that pin's flag
// - flags stay set until software clears
// - clear needs flag read, then zero write
// - gpio or irq-input pins never change flags
// - programmable vector for edge interrupt
// - edge level resets zero; zero disables
// - edge interrupt loses same-level arbitration
// - port C latch drives discrete-output pins
// - field codes: discrete, alternate, cs8, cs16
// - boot field offers only chip-select codes
// - bits 15:14 read zero, bit 1 one
// - cs field upper bits and boot field low bit strapped from data lines
// - cs5-3 discrete bits 2-0; cs2-0 none
// - pin assignment writable any time after reset
// - periodic level zero disables timer interrupt
// - periodic vector supplied on acknowledge
`timescale 1ns/1ps
`include "sipw_defs.svh"

module sipw_top
	import sipw_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire sipw_ahb_in_t ahb_in,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic mode_clock_pin,
	input wire logic [2:0] data_bus_strap,
	input wire logic fast_ref,
	input wire logic ext_clock,
	input wire logic [7:0] port_f_pins,
	input wire logic irq_ack,
	output sipw_irq_t irq,
	output logic wd_restart,
	output logic [15:0] pin_function,
	output logic [2:0] discrete_out,
	output logic [2:0] discrete_out_en
);

	sipw_state_t st_ff;
	sipw_state_t nxt_st;

	logic accept;
	logic dp_wr;
	logic [7:0] wr_byte;
	logic [7:0] edge_hit;
	logic [7:0] quiet_pin;
	logic [7:0] clr_mask;
	logic [9:0] base_len;
	logic base_tick;
	logic pre_wrap;
	logic pre_tick;
	logic pit_act;
	logic edge_act;
	logic [31:0] rd_val;

	assign accept = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
	assign dp_wr = st_ff.dp_valid && st_ff.dp_write;
	assign wr_byte = ahb_in.hwdata[7:0];

	// a flag clears only where the last read of the flag register saw it set
	assign clr_mask = (dp_wr && st_ff.dp_addr == `SIPW_OFS_EDGE_FLAGS) ? (~wr_byte & st_ff.seen) : 8'h00;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_edge
			logic [1:0] mode;
			assign mode = st_ff.edge_cfg[2*gi +: 2];
			assign quiet_pin[gi] = !mode[1];
			// gpio and irq-input modes give no hit at all
			assign edge_hit[gi] = (mode == `SIPW_EM_RISE && port_f_pins[gi] && !st_ff.pin_prev[gi]) ||
				(mode == `SIPW_EM_FALL && !port_f_pins[gi] && st_ff.pin_prev[gi]);
		end
	endgenerate

	// fast reference stretches each timebase step by 128; external clock ignores reference type
	assign base_len = (fast_ref && !ext_clock) ? 10'(`SIPW_REF_DIV * `SIPW_FAST_MULT) :
		10'(`SIPW_REF_DIV);
	// a step cut short by a mode change mid-count ends at once instead of running round the counter
	assign base_tick = (st_ff.base_cnt >= base_len - 10'h001);
	assign pre_wrap = !st_ff.periodic_prescale_select || (st_ff.pre_cnt == 9'(`SIPW_PRESCALE - 1));
	assign pre_tick = base_tick && pre_wrap;

	assign pit_act = st_ff.pit_pend && (st_ff.pit_level != 3'h0);
	assign edge_act = (st_ff.flags != 8'h00) && (st_ff.edge_level != 3'h0);

	always_comb begin
		rd_val = 32'h0000_0000;
		case (ahb_in.haddr[7:0])
			`SIPW_OFS_PIT_CTRL: rd_val = {21'h000000, st_ff.pit_level, st_ff.pit_vector};
			`SIPW_OFS_PIT_MOD: rd_val = {23'h000000, st_ff.periodic_prescale_select, st_ff.modulus};
			`SIPW_OFS_WD_SVC: rd_val = 32'h0000_0000;
			`SIPW_OFS_EDGE_FLAGS: rd_val = {24'h000000, st_ff.flags};
			`SIPW_OFS_EDGE_VEC: rd_val = {24'h000000, st_ff.edge_vector};
			`SIPW_OFS_EDGE_LVL: rd_val = {29'h00000000, st_ff.edge_level};
			`SIPW_OFS_PORT_C: rd_val = {24'h000000, st_ff.port_c};
			`SIPW_OFS_PIN_ASSIGN: rd_val = {16'h0000, st_ff.pin_assign};
			`SIPW_OFS_EDGE_CFG: rd_val = {16'h0000, st_ff.edge_cfg};
			default: rd_val = 32'h0000_0000;
		endcase
		if (ahb_in.haddr[31:8] != 24'h000000) begin
			rd_val = 32'h0000_0000;
		end
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.wd_restart = 1'b0;
		nxt_st.hreadyout = 1'b1;
		nxt_st.hresp = 1'b0;

		// straps are caught on the first edge after release, never under the async reset
		if (!st_ff.strapped) begin
			nxt_st.strapped = 1'b1;
			nxt_st.periodic_prescale_select = mode_clock_pin;
			nxt_st.pin_assign[13] = data_bus_strap[2];
			nxt_st.pin_assign[11] = data_bus_strap[2];
			nxt_st.pin_assign[9] = data_bus_strap[2];
			nxt_st.pin_assign[7] = data_bus_strap[1];
			nxt_st.pin_assign[5] = data_bus_strap[1];
			nxt_st.pin_assign[3] = data_bus_strap[1];
			nxt_st.pin_assign[0] = data_bus_strap[0];
		end

		// periodic timebase and prescaler
		nxt_st.base_cnt = base_tick ? 10'h000 : st_ff.base_cnt + 10'h001;
		if (base_tick) begin
			nxt_st.pre_cnt = pre_wrap ? 9'h000 : st_ff.pre_cnt + 9'h001;
		end

		// acknowledge clears the pending timer request; a new expiry in the same cycle wins below
		if (irq_ack && st_ff.irq.req && st_ff.irq.src_pit) begin
			nxt_st.pit_pend = 1'b0;
		end
		if (st_ff.modulus == 8'h00) begin
			nxt_st.pit_cnt = 8'h00;
		end else if (pre_tick) begin
			if (st_ff.pit_cnt <= 8'h01) begin
				nxt_st.pit_cnt = st_ff.modulus;
				nxt_st.pit_pend = 1'b1;
			end else begin
				nxt_st.pit_cnt = st_ff.pit_cnt - 8'h01;
			end
		end

		// edge flags: set wins over clear
		nxt_st.pin_prev = port_f_pins;
		nxt_st.flags = (st_ff.flags & ~clr_mask) | edge_hit;

		// data phase of a write
		if (dp_wr) begin
			case (st_ff.dp_addr)
				`SIPW_OFS_PIT_CTRL: begin
					nxt_st.pit_level = ahb_in.hwdata[10:8];
					nxt_st.pit_vector = wr_byte;
				end
				`SIPW_OFS_PIT_MOD: begin
					nxt_st.periodic_prescale_select = ahb_in.hwdata[8];
					nxt_st.modulus = wr_byte;
					// restart the interval from the new modulus
					nxt_st.pit_cnt = wr_byte;
					nxt_st.pre_cnt = 9'h000;
				end
				`SIPW_OFS_WD_SVC: begin
					// any other value breaks the pair; other registers leave it alone
					if (wr_byte == `SIPW_WD_KEY1) begin
						nxt_st.wd_state = wd_armed;
					end else if (wr_byte == `SIPW_WD_KEY2 && st_ff.wd_state == wd_armed) begin
						nxt_st.wd_state = wd_idle;
						nxt_st.wd_restart = 1'b1;
					end else begin
						nxt_st.wd_state = wd_idle;
					end
				end
				`SIPW_OFS_EDGE_FLAGS: begin
					nxt_st.seen = 8'h00;
				end
				`SIPW_OFS_EDGE_VEC: begin
					nxt_st.edge_vector = wr_byte;
				end
				`SIPW_OFS_EDGE_LVL: begin
					nxt_st.edge_level = ahb_in.hwdata[2:0];
				end
				`SIPW_OFS_PORT_C: begin
					nxt_st.port_c = wr_byte;
				end
				`SIPW_OFS_PIN_ASSIGN: begin
					// top pair stays zero, boot high bit stays one so only chip-select codes remain
					nxt_st.pin_assign = {2'h0, ahb_in.hwdata[13:2], 1'b1, ahb_in.hwdata[0]};
				end
				`SIPW_OFS_EDGE_CFG: begin
					nxt_st.edge_cfg = ahb_in.hwdata[15:0];
				end
				default: begin
					nxt_st.dp_valid = st_ff.dp_valid;
				end
			endcase
		end

		// address phase; zero wait states, so read data is captured here
		if (accept) begin
			nxt_st.dp_valid = 1'b1;
			nxt_st.dp_write = ahb_in.hwrite;
			nxt_st.dp_addr = (ahb_in.haddr[31:8] == 24'h000000) ? ahb_in.haddr[7:0] : 8'hfc;
			if (!ahb_in.hwrite) begin
				nxt_st.hrdata = rd_val;
				if (ahb_in.haddr == {24'h000000, `SIPW_OFS_EDGE_FLAGS}) begin
					nxt_st.seen = st_ff.flags;
				end
			end
		end else begin
			nxt_st.dp_valid = 1'b0;
		end

		// arbitration: timer wins ties, so the edge source loses at equal level
		if (pit_act && (!edge_act || st_ff.pit_level >= st_ff.edge_level)) begin
			nxt_st.irq.req = 1'b1;
			nxt_st.irq.level = st_ff.pit_level;
			nxt_st.irq.vector = st_ff.pit_vector;
			nxt_st.irq.src_pit = 1'b1;
		end else if (edge_act) begin
			nxt_st.irq.req = 1'b1;
			nxt_st.irq.level = st_ff.edge_level;
			nxt_st.irq.vector = st_ff.edge_vector;
			nxt_st.irq.src_pit = 1'b0;
		end else begin
			nxt_st.irq = '0;
		end

		// cs3..cs5 carry discrete bits 0..2; cs0..cs2 have no discrete output
		for (int i = 0; i < 3; i++) begin
			nxt_st.disc_oe[i] = (st_ff.pin_assign[8 + 2*i +: 2] == `SIPW_PF_DISCRETE);
			nxt_st.disc_out[i] = st_ff.port_c[i];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
			st_ff.hreadyout <= 1'b1;
			st_ff.pit_vector <= `SIPW_PIT_VEC_RST;
			st_ff.pit_level <= `SIPW_PIT_LVL_RST;
			st_ff.edge_vector <= `SIPW_EDGE_VEC_RST;
			st_ff.edge_level <= `SIPW_EDGE_LVL_RST;
			st_ff.pin_assign <= `SIPW_PIN_ASSIGN_RST;
			st_ff.wd_state <= wd_idle;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hrdata = st_ff.hrdata;
	assign hreadyout = st_ff.hreadyout;
	assign hresp = st_ff.hresp;
	assign irq = st_ff.irq;
	assign wd_restart = st_ff.wd_restart;
	assign pin_function = st_ff.pin_assign;
	assign discrete_out = st_ff.disc_out;
	assign discrete_out_en = st_ff.disc_oe;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	chk_wd_pair_order: assert property (
		st_ff.wd_restart |-> $past(st_ff.wd_state) == wd_armed && $past(dp_wr) &&
			$past(st_ff.dp_addr) == `SIPW_OFS_WD_SVC)
		else $error("watchdog restart without armed pair");

	chk_wd_armed_holds: assert property (
		(st_ff.wd_state == wd_armed && !(dp_wr && st_ff.dp_addr == `SIPW_OFS_WD_SVC))
			|=> st_ff.wd_state == wd_armed && !st_ff.wd_restart)
		else $error("watchdog sequence lost on unrelated access");

	chk_flag_sticky: assert property (
		1'b1 |=> ((st_ff.flags & $past(st_ff.flags & ~clr_mask)) == $past(st_ff.flags & ~clr_mask)))
		else $error("edge flag dropped without clear");

	chk_flag_clear_read: assert property (
		1'b1 |=> ((($past(st_ff.flags) & ~st_ff.flags) & ~$past(st_ff.seen)) == 8'h00))
		else $error("edge flag cleared without prior read");

	chk_flag_set_edge: assert property (
		1'b1 |=> ((~$past(st_ff.flags) & st_ff.flags) == $past(edge_hit & ~st_ff.flags)))
		else $error("edge flag set without matching edge");

	chk_edge_lvl_off: assert property (
		(st_ff.edge_level == 3'h0 && !pit_act) |=> !st_ff.irq.req)
		else $error("edge interrupt raised at level zero");

	chk_arb_pit_wins: assert property (
		(pit_act && edge_act && st_ff.pit_level == st_ff.edge_level)
			|=> st_ff.irq.req && st_ff.irq.src_pit && st_ff.irq.vector == $past(st_ff.pit_vector))
		else $error("edge source won same-level arbitration");

	chk_assign_fixed: assert property (
		st_ff.pin_assign[15:14] == 2'h0 && st_ff.pin_assign[1] == 1'b1)
		else $error("pin assignment fixed bits wrong");

	chk_pit_stopped: assert property (
		(st_ff.modulus == 8'h00 && !st_ff.pit_pend) [*2] |-> st_ff.pit_cnt == 8'h00 && !st_ff.pit_pend)
		else $error("periodic timer ran with zero modulus");

	chk_disc_follow: assert property (
		st_ff.strapped |=> st_ff.disc_out == $past(st_ff.port_c[2:0]) &&
			st_ff.disc_oe[0] == ($past(st_ff.pin_assign[9:8]) == `SIPW_PF_DISCRETE))
		else $error("discrete output not following latch");

	chk_bus_always_okay: assert property (
		st_ff.hreadyout && !st_ff.hresp)
		else $error("bus slave stalled or answered an error");

	chk_slow_step: assert property (
		((!fast_ref || ext_clock) && st_ff.base_cnt == 10'(`SIPW_REF_DIV - 1)) |-> base_tick)
		else $error("slow timebase step longer than four clocks");

	chk_fast_step: assert property (
		(base_tick && fast_ref && !ext_clock) |-> st_ff.base_cnt == 10'(`SIPW_REF_DIV * `SIPW_FAST_MULT - 1))
		else $error("fast timebase step not 128 times longer");

	chk_prescale_wrap: assert property (
		(pre_tick && st_ff.periodic_prescale_select) |-> st_ff.pre_cnt == 9'(`SIPW_PRESCALE - 1))
		else $error("prescaled step shorter than 512 timebase steps");

	chk_pit_reload: assert property (
		(pre_tick && st_ff.modulus != 8'h00 && st_ff.pit_cnt <= 8'h01 &&
			!(dp_wr && st_ff.dp_addr == `SIPW_OFS_PIT_MOD)) |=> st_ff.pit_pend && st_ff.pit_cnt == $past(st_ff.modulus))
		else $error("periodic timer missed its expiry or reload");

	chk_pit_lvl_off: assert property (
		(st_ff.pit_level == 3'h0 && !edge_act) |=> !st_ff.irq.req)
		else $error("timer interrupt raised at level zero");

	chk_pit_vector: assert property (
		(pit_act && !edge_act) |=> st_ff.irq.req && st_ff.irq.src_pit && st_ff.irq.vector == $past(st_ff.pit_vector) &&
			st_ff.irq.level == $past(st_ff.pit_level))
		else $error("timer interrupt carries wrong vector or level");

	chk_edge_vector: assert property (
		(edge_act && !pit_act) |=> st_ff.irq.req && !st_ff.irq.src_pit && st_ff.irq.vector == $past(st_ff.edge_vector))
		else $error("edge interrupt carries wrong vector");

	chk_edge_quiet: assert property (
		1'b1 |=> ((st_ff.flags & ~$past(st_ff.flags) & $past(quiet_pin)) == 8'h00))
		else $error("edge flag set on a gpio or irq-input pin");

	chk_strap_capture: assert property (
		!st_ff.strapped |=> st_ff.strapped && st_ff.periodic_prescale_select == $past(mode_clock_pin) &&
			st_ff.pin_assign[13] == $past(data_bus_strap[2]) && st_ff.pin_assign[7] == $past(data_bus_strap[1]) &&
			st_ff.pin_assign[0] == $past(data_bus_strap[0]))
		else $error("reset straps not captured");

	chk_wd_single_pulse: assert property (
		st_ff.wd_restart |=> !st_ff.wd_restart)
		else $error("watchdog restart longer than one cycle");

	chk_pin_write: assert property (
		(dp_wr && st_ff.dp_addr == `SIPW_OFS_PIN_ASSIGN) |=> st_ff.pin_assign[13:2] == $past(ahb_in.hwdata[13:2]))
		else $error("pin assignment write not taken");

	chk_latch_write: assert property (
		(dp_wr && st_ff.dp_addr == `SIPW_OFS_PORT_C) |=> st_ff.port_c == $past(wr_byte))
		else $error("discrete output latch write not taken");

endmodule

// ===== shared/sipw_defs.svh
// register offsets, field codes, reset values and timing counts of the system-integration slice
`ifndef SIPW_DEFS_SVH
`define SIPW_DEFS_SVH

`define SIPW_OFS_PIT_CTRL 8'h00
`define SIPW_OFS_PIT_MOD 8'h04
`define SIPW_OFS_WD_SVC 8'h08
`define SIPW_OFS_EDGE_FLAGS 8'h0c
`define SIPW_OFS_EDGE_VEC 8'h10
`define SIPW_OFS_EDGE_LVL 8'h14
`define SIPW_OFS_PORT_C 8'h18
`define SIPW_OFS_PIN_ASSIGN 8'h1c
`define SIPW_OFS_EDGE_CFG 8'h20

`define SIPW_REF_DIV 4
`define SIPW_FAST_MULT 128
`define SIPW_PRESCALE 512

`define SIPW_WD_KEY1 8'h55
`define SIPW_WD_KEY2 8'haa

`define SIPW_PIT_VEC_RST 8'h0f
`define SIPW_PIT_LVL_RST 3'h0
`define SIPW_EDGE_VEC_RST 8'h0f
`define SIPW_EDGE_LVL_RST 3'h0
`define SIPW_PIN_ASSIGN_RST 16'h3fff

`define SIPW_PF_DISCRETE 2'h0
`define SIPW_PF_ALTERNATE 2'h1
`define SIPW_PF_CS8 2'h2
`define SIPW_PF_CS16 2'h3

`define SIPW_EM_GPIO 2'h0
`define SIPW_EM_IRQ_IN 2'h1
`define SIPW_EM_RISE 2'h2
`define SIPW_EM_FALL 2'h3

`endif

// ===== shared/sipw_pkg.sv
// types shared by the system-integration slice
package sipw_pkg;

	typedef enum logic {
		wd_idle,
		wd_armed
	} sipw_wd_state_t;

	typedef struct packed {
		logic hsel;
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hready;
		logic [31:0] hwdata;
	} sipw_ahb_in_t;

	typedef struct packed {
		logic req;
		logic [2:0] level;
		logic [7:0] vector;
		logic src_pit;
	} sipw_irq_t;

	typedef struct packed {
		logic strapped;
		logic dp_valid;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic [2:0] pit_level;
		logic [7:0] pit_vector;
		logic periodic_prescale_select;
		logic [7:0] modulus;
		logic [9:0] base_cnt;
		logic [8:0] pre_cnt;
		logic [7:0] pit_cnt;
		logic pit_pend;
		sipw_wd_state_t wd_state;
		logic wd_restart;
		logic [7:0] flags;
		logic [7:0] seen;
		logic [15:0] edge_cfg;
		logic [7:0] pin_prev;
		logic [7:0] edge_vector;
		logic [2:0] edge_level;
		logic [7:0] port_c;
		logic [15:0] pin_assign;
		sipw_irq_t irq;
		logic [2:0] disc_out;
		logic [2:0] disc_oe;
	} sipw_state_t;

endpackage

// ===== testbench/sipw_top_tb.sv
// self-checking bench for the system-integration slice
`timescale 1ns/1ps

module sipw_top_tb;
	import sipw_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	sipw_ahb_in_t bus;
	sipw_ahb_in_t ahb_w;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic fast_ref = 1'b0;
	logic ext_clock = 1'b0;
	logic mode_clk = 1'b1;
	logic [2:0] strap = 3'h5;
	logic [7:0] port_f_pins = 8'h02;
	logic ack_auto = 1'b0;
	logic ack_man = 1'b0;
	logic auto_ack = 1'b1;
	logic pit_on;
	logic pit_prev = 1'b0;
	sipw_irq_t irq;
	logic wd_restart;
	logic [15:0] pin_function;
	logic [2:0] discrete_out;
	logic [2:0] discrete_out_en;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	int last = 0;
	int period = 0;
	int rises = 0;
	int wd_pulses = 0;

	always #10 hclk = ~hclk;

	always_comb begin
		ahb_w = bus;
		ahb_w.hready = hreadyout;
	end

	assign pit_on = (irq.req === 1'b1) && (irq.src_pit === 1'b1);

	sipw_top i_dut (
		.hclk(hclk),
		.hresetn(hresetn),
		.ahb_in(ahb_w),
		.hrdata(hrdata),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.mode_clock_pin(mode_clk),
		.data_bus_strap(strap),
		.fast_ref(fast_ref),
		.ext_clock(ext_clock),
		.port_f_pins(port_f_pins),
		.irq_ack(ack_auto | ack_man),
		.irq(irq),
		.wd_restart(wd_restart),
		.pin_function(pin_function),
		.discrete_out(discrete_out),
		.discrete_out_en(discrete_out_en)
	);

	// timer requests are acknowledged at once so each expiry shows as a fresh rise of the request
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		pit_prev <= pit_on;
		ack_auto <= auto_ack && pit_on && !ack_auto;
		if (wd_restart === 1'b1)
			wd_pulses <= wd_pulses + 1;
		if (pit_on && !pit_prev) begin
			period <= cyc - last;
			last <= cyc;
			rises <= rises + 1;
		end
	end

	always @(posedge hclk) begin
		if (cyc == 40000) begin
			num_errors++;
			$display("unexpected timeout at cycle %0d", cyc);
			stop_test();
		end
	end

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic addr_phase(input logic [7:0] a, input logic wr_en);
		bus.hsel <= 1'b1;
		bus.haddr <= {24'h0, a};
		bus.htrans <= 2'h2;
		bus.hwrite <= wr_en;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		bus.hsel <= 1'b0;
		bus.htrans <= 2'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_phase(a, 1'b1);
		bus.hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask

	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		addr_phase(a, 1'b0);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		check(nm, hrdata, exp);
		check("hresp", {31'h0, hresp}, 32'h0);
	endtask

	task automatic end_test(input string nm);
		$display("test %s done", nm);
	endtask

	// the first expiry after a modulus write may be short, so the third interval is judged
	task automatic pit_period(input logic [31:0] mv, input logic fr, input logic ex, input int expv);
		int base;
		fast_ref <= fr;
		ext_clock <= ex;
		wr(8'h04, mv);
		base = rises;
		while (rises < base + 3)
			@(posedge hclk);
		check("pit_period", period, expv);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		int base;
		bus = '0;
		bus.hsize = 3'h2;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rd_chk("pit_ctrl", 8'h00, 32'h0f);
		rd_chk("pit_mod", 8'h04, 32'h100);
		rd_chk("edge_vec", 8'h10, 32'h0f);
		rd_chk("edge_lvl", 8'h14, 32'h0);
		rd_chk("pin_assign", 8'h1c, 32'h3f57);
		rd_chk("wd_svc", 8'h08, 32'h0);
		wr(8'h40, 32'h1234);
		rd_chk("unmapped", 8'h40, 32'h0);
		end_test("reset");
		wr(8'h1c, 32'h0fff);
		wr(8'h18, 32'h05);
		rd_chk("pin_assign", 8'h1c, 32'h0fff);
		check("pin_function", {16'h0, pin_function}, 32'h0fff);
		check("disc_en", {29'h0, discrete_out_en}, 32'h4);
		check("disc_out", {29'h0, discrete_out}, 32'h5);
		rd_chk("port_c", 8'h18, 32'h05);
		wr(8'h1c, 32'h0);
		rd_chk("pin_assign", 8'h1c, 32'h2);
		check("disc_en", {29'h0, discrete_out_en}, 32'h7);
		wr(8'h1c, 32'hffff);
		rd_chk("pin_assign", 8'h1c, 32'h3fff);
		check("disc_en", {29'h0, discrete_out_en}, 32'h0);
		end_test("pin_assign");
		wr(8'h08, 32'h55);
		wr(8'h18, 32'h05);
		rd_chk("pit_ctrl", 8'h00, 32'h0f);
		wr(8'h08, 32'haa);
		repeat (2) @(posedge hclk);
		check("wd_pulses", wd_pulses, 32'h1);
		wr(8'h08, 32'haa);
		repeat (2) @(posedge hclk);
		check("wd_pulses", wd_pulses, 32'h1);
		wr(8'h08, 32'h55);
		wr(8'h08, 32'h12);
		wr(8'h08, 32'haa);
		repeat (2) @(posedge hclk);
		check("wd_pulses", wd_pulses, 32'h1);
		end_test("watchdog");
		wr(8'h20, 32'h4e);
		port_f_pins <= 8'h0d;
		repeat (3) @(posedge hclk);
		rd_chk("flags", 8'h0c, 32'h3);
		port_f_pins <= 8'h00;
		wr(8'h0c, 32'h3);
		wr(8'h0c, 32'h0);
		rd_chk("flags", 8'h0c, 32'h3);
		wr(8'h0c, 32'h2);
		rd_chk("flags", 8'h0c, 32'h2);
		end_test("edge_flags");
		wr(8'h00, 32'h350);
		rd_chk("pit_ctrl", 8'h00, 32'h350);
		pit_period(32'h3, 1'b0, 1'b0, 12);
		pit_period(32'h3, 1'b1, 1'b0, 1536);
		pit_period(32'h3, 1'b1, 1'b1, 12);
		pit_period(32'h101, 1'b0, 1'b0, 2048);
		wr(8'h04, 32'h0);
		repeat (4) @(posedge hclk);
		base = rises;
		repeat (600) @(posedge hclk);
		check("pit_stopped", rises - base, 32'h0);
		end_test("timer");
		auto_ack <= 1'b0;
		wr(8'h10, 32'h40);
		repeat (2) @(posedge hclk);
		check("irq_req", {31'h0, irq.req}, 32'h0);
		wr(8'h14, 32'h3);
		repeat (2) @(posedge hclk);
		check("irq", {19'h0, irq}, {19'h0, 1'b1, 3'h3, 8'h40, 1'b0});
		wr(8'h04, 32'h1);
		repeat (20) @(posedge hclk);
		check("irq", {19'h0, irq}, {19'h0, 1'b1, 3'h3, 8'h50, 1'b1});
		wr(8'h04, 32'h0);
		ack_man <= 1'b1;
		@(posedge hclk);
		ack_man <= 1'b0;
		repeat (3) @(posedge hclk);
		check("irq", {19'h0, irq}, {19'h0, 1'b1, 3'h3, 8'h40, 1'b0});
		wr(8'h00, 32'h050);
		wr(8'h14, 32'h0);
		repeat (2) @(posedge hclk);
		check("irq_req", {31'h0, irq.req}, 32'h0);
		end_test("interrupt");
		// set the prescale bit first; reset clears it to zero and the fresh strap then loads the low mode pin
		wr(8'h04, 32'h100);
		mode_clk <= 1'b0;
		strap <= 3'h2;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (2) @(posedge hclk);
		rd_chk("pit_mod", 8'h04, 32'h0);
		rd_chk("pin_assign", 8'h1c, 32'h15fe);
		rd_chk("edge_lvl", 8'h14, 32'h0);
		check("disc_en", {29'h0, discrete_out_en}, 32'h0);
		end_test("restrap");
		stop_test();
	end
endmodule
